// ---- rtl/apg_pkg.sv ----
// apg_pkg: constants and types for the converter output processing path
// assumes: used by apg_top and apg_gain, single sampling clock domain
package apg_pkg;

  // ===========================================================
  // data widths
  // ===========================================================
  localparam int APG_DW = 14;                       // full resolution word
  localparam int APG_DW12 = 12;                     // reduced resolution word
  localparam int APG_GW = 4;                        // gain code width

  // ===========================================================
  // latencies in sampling clock cycles
  // ===========================================================
  localparam int APG_BYPASS_LAT = 10;               // raw path latency
  localparam int APG_PROC_EXTRA = 4;                // fixed extra latency of processing path
  localparam int APG_PROC_LAT = APG_BYPASS_LAT + APG_PROC_EXTRA;
  localparam int APG_GAIN_STAGES = 2;               // register stages inside the gain module

  // ===========================================================
  // gain settings: code n means n * 0.5 dB, 0..12
  // ===========================================================
  localparam logic [3:0] APG_GAIN_RESET = 4'h0;     // 0 dB
  localparam logic [3:0] APG_GAIN_MAX = 4'hC;       // 6 dB
  localparam int APG_MULT_FRAC = 12;                // fraction bits of the multiplier
  localparam logic [13:0] APG_OB_MAX = 14'h3FFF;    // top offset binary code
  localparam logic [13:0] APG_OB_MIN = 14'h0000;    // bottom offset binary code
  localparam logic [13:0] APG_MID = 14'h2000;       // midscale of offset binary

  // ===========================================================
  // path state
  // ===========================================================
  typedef enum logic [1:0] {
    APG_ST_BYPASS = 2'b00,                          // raw data to pins
    APG_ST_FILL = 2'b01,                            // processing pipe refilling
    APG_ST_PROC = 2'b11                             // processed data to pins
  } apg_state_type;

  // gain multiplier 10^(n*0.5/20) in Q1.12, which also scales full scale
  function automatic logic [13:0] apg_gain_mult(input logic [3:0] code);
    case (code)
      4'h0: apg_gain_mult = 14'h1000;
      4'h1: apg_gain_mult = 14'h10F4;
      4'h2: apg_gain_mult = 14'h11F6;
      4'h3: apg_gain_mult = 14'h1307;
      4'h4: apg_gain_mult = 14'h1429;
      4'h5: apg_gain_mult = 14'h155C;
      4'h6: apg_gain_mult = 14'h16A0;
      4'h7: apg_gain_mult = 14'h17F7;
      4'h8: apg_gain_mult = 14'h1962;
      4'h9: apg_gain_mult = 14'h1AE1;
      4'hA: apg_gain_mult = 14'h1C76;
      4'hB: apg_gain_mult = 14'h1E22;
      4'hC: apg_gain_mult = 14'h1FE8;
      default: apg_gain_mult = 14'h1FE8;
    endcase
  endfunction : apg_gain_mult

  // convert offset binary to two's complement by flipping the top bit
  function automatic logic [13:0] apg_to_twos(input logic [13:0] ob);
    apg_to_twos = {~ob[13], ob[12:0]};
  endfunction : apg_to_twos

endpackage : apg_pkg

// ---- rtl/apg_gain_if.sv ----
// apg_gain_if: carries samples and gain setting between top and gain stage
// assumes: both ends on ref_clk
`timescale 1ns/1ns
interface apg_gain_if;
  logic [13:0] in_data;                             // offset binary sample in
  logic [3:0] gain_code;                            // active gain code
  logic [13:0] out_data;                            // scaled, saturated sample
  modport top (output in_data, output gain_code, input out_data);
  modport gain (input in_data, input gain_code, output out_data);
endinterface : apg_gain_if

// ---- rtl/apg_gain.sv ----
// apg_gain: two-stage fixed-latency gain multiplier with saturation
// assumes: offset binary input, gain code already limited to 0..12
`timescale 1ns/1ns
module apg_gain
  import apg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  apg_gain_if.gain g
);

  // ===========================================================
  // stage 1: signed product
  // ===========================================================
  logic signed [14:0] centred;                      // sample around midscale
  logic signed [29:0] prod_q;                       // registered product
  logic signed [29:0] prod_d;
  logic signed [17:0] scaled;                       // product back in sample units
  logic [13:0] sat_val;                             // clamped offset binary result
  logic [13:0] out_q;

  assign centred = $signed({1'b0, g.in_data}) - $signed({1'b0, APG_MID});
  assign prod_d = 30'(centred * $signed({1'b0, apg_gain_mult(g.gain_code)})); // see RL9
  assign scaled = $signed(prod_q[APG_MULT_FRAC +: 18]);

  // clamp instead of wrapping: a wrap would turn overload into a full-scale flip
  assign sat_val = (scaled > 18'sh0_1FFF) ? APG_OB_MAX :             // see RL13
                   (scaled < -18'sh0_2000) ? APG_OB_MIN :           // see RL13
                   14'(scaled + 18'sh0_2000);

  // product register, same depth for every gain code
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_q <= '0;
    end else begin
      prod_q <= prod_d;                             // see RL12
    end
  end

  // ===========================================================
  // stage 2: saturated output register
  // ===========================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= APG_MID;
    end else begin
      out_q <= sat_val;
    end
  end

  assign g.out_data = out_q;

endmodule : apg_gain

// ---- rtl/apg_top.sv ----
// apg_top: output-side processing path of a pipelined converter
// assumes: raw samples arrive one per ref_clk edge from the stage pipeline,
// control pins come from a programming block on another clock
//
// Operation
// RL1 - reset leaves the path in bypass
// RL2 - bypass output ten cycles after sampling
// RL3 - bypass skips patterns, gain and offset
// RL4 - processing path adds extra pipeline cycles
// RL5 - processing only while bypass_disable is one
// RL6 - gain 0 to 6 dB, half dB steps
// RL7 - leaving bypass starts gain at 0 dB
// RL8 - gain inactive right after reset
// RL9 - gain scales full scale, 0 dB 2 Vpp
// RL10 - one pipeline step per rising edge
// RL11 - 14 or 12 bit, offset or twos
// RL12 - fixed extra latency for every gain
// RL13 - gain saturates rather than wraps
`timescale 1ns/1ns
module apg_top
  import apg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [13:0] raw_sample,
  input wire logic bypass_disable,
  input wire logic [3:0] gain_sel,
  input wire logic twos_comp,
  input wire logic res12,
  output logic [13:0] out_data,
  output logic proc_active
);

  // ===========================================================
  // control synchronisers (pins from outside the clock domain)
  // ===========================================================
  logic [5:0] ctl_s1_q;                              // first stage, read only by ctl_s2_q
  logic [5:0] ctl_s2_q;
  logic [3:0] gain_q;                                // gain actually applied
  logic [3:0] gain_d;
  logic byp_dis;
  logic [3:0] gain_pin;
  apg_state_type state_q;
  apg_state_type state_d;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
    end else begin
      ctl_s1_q <= {bypass_disable, gain_sel, twos_comp};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  logic fmt_twos;
  logic res12_s1_q;
  logic res12_q;
  assign byp_dis = ctl_s2_q[5];
  assign gain_pin = ctl_s2_q[4:1];
  assign fmt_twos = ctl_s2_q[0];

  // a multi-bit code can be caught mid-change by the synchroniser; a third copy
  // lets the gain follow the pins only once two samples in a row agree
  logic [3:0] gain_s3_q;
  logic gain_steady;
  assign gain_steady = (gain_pin == gain_s3_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_s3_q <= APG_GAIN_RESET;
    end else begin
      gain_s3_q <= gain_pin;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res12_s1_q <= 1'b0;
      res12_q <= 1'b0;
    end else begin
      res12_s1_q <= res12;
      res12_q <= res12_s1_q;
    end
  end

  // ===========================================================
  // raw delay line: one step per rising edge
  // ===========================================================
  // the input is taken as the sample of this edge; stage k holds it k+1 edges later
  logic [13:0] raw_pipe_q [APG_PROC_LAT];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < APG_PROC_LAT; i++) begin
        raw_pipe_q[i] <= APG_MID;
      end
    end else begin
      raw_pipe_q[0] <= raw_sample;                   // see RL10
      for (int i = 1; i < APG_PROC_LAT; i++) begin
        raw_pipe_q[i] <= raw_pipe_q[i-1];            // see RL10
      end
    end
  end

  // ===========================================================
  // gain control
  // ===========================================================
  // out of range codes clamp to 6 dB; in bypass the gain is held at 0 dB
  assign gain_d = !byp_dis ? APG_GAIN_RESET :                      // see RL7
                  !gain_steady ? gain_q :                          // torn code: hold
                  (gain_pin > APG_GAIN_MAX) ? APG_GAIN_MAX : gain_pin;  // see RL6

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= APG_GAIN_RESET;                      // see RL8
    end else begin
      gain_q <= gain_d;
    end
  end

  // ===========================================================
  // processing path: taps the delay line early, gain adds its stages
  // ===========================================================
  apg_gain_if gif ();
  // tap plus the gain stages plus the output flop adds up to the processed latency
  assign gif.in_data = raw_pipe_q[APG_PROC_LAT - APG_GAIN_STAGES - 2];  // see RL4
  assign gif.gain_code = gain_q;

  apg_gain u_gain (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .g (gif.gain)
  );

  // ===========================================================
  // mode state: bypass / refill / processed
  // ===========================================================
  logic [3:0] fill_cnt_q;
  logic [3:0] fill_cnt_d;
  logic fill_done;
  assign fill_done = fill_cnt_q == 4'(APG_PROC_EXTRA - 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      APG_ST_BYPASS: begin
        if (byp_dis) state_d = APG_ST_FILL;          // see RL5
      end
      APG_ST_FILL: begin
        if (!byp_dis) state_d = APG_ST_BYPASS;
        else if (fill_done) state_d = APG_ST_PROC;
      end
      APG_ST_PROC: begin
        if (!byp_dis) state_d = APG_ST_BYPASS;       // see RL5
      end
      default: state_d = APG_ST_BYPASS;
    endcase
  end
  assign fill_cnt_d = (state_q == APG_ST_FILL) ? fill_cnt_q + 4'h1 : 4'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= APG_ST_BYPASS;                      // see RL1
      fill_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      fill_cnt_q <= fill_cnt_d;
    end
  end

  // ===========================================================
  // output select and format
  // ===========================================================
  // during refill the raw word is still shown, so the pins never carry stale data
  logic [13:0] sel_word;
  logic [13:0] fmt_word;
  logic [13:0] out_q;
  logic use_proc;
  assign use_proc = (state_q == APG_ST_PROC);
  // bypass takes the tap nine stages in, plus the output flop makes ten
  assign sel_word = use_proc ? gif.out_data                        // see RL4
                             : raw_pipe_q[APG_BYPASS_LAT - 2];     // see RL2 see RL3
  assign fmt_word = fmt_twos ? apg_to_twos(sel_word) : sel_word;   // see RL11
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= APG_MID;
    end else begin
      out_q <= res12_q ? {fmt_word[13:2], 2'b00} : fmt_word;       // see RL11
    end
  end
  assign out_data = out_q;
  assign proc_active = use_proc;

  // ===========================================================
  // checks
  // ===========================================================
  // edges since reset, saturating: latency checks wait until the delay line holds
  // real samples, since $past looks back across the reset
  logic [3:0] warm_q;
  logic [3:0] warm_d;
  logic warm;
  assign warm = (warm_q == 4'(APG_PROC_LAT));
  assign warm_d = warm ? warm_q : warm_q + 4'h1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 4'h0;
    end else begin
      warm_q <= warm_d;
    end
  end

  sequence s_enter_proc;
    !use_proc ##1 use_proc;
  endsequence

  property p_bypass_lat;
    @(posedge ref_clk) disable iff (!rst_n)
    (warm && !use_proc && !fmt_twos && !res12_q) [*1] |=> out_data == $past(raw_sample, 10);
  endproperty
  a_bypass_lat: assert property (p_bypass_lat) else $error("bypass latency wrong"); // see RL2

  property p_no_proc_without_bit;
    @(posedge ref_clk) disable iff (!rst_n) !byp_dis |=> !use_proc;
  endproperty
  a_no_proc_without_bit: assert property (p_no_proc_without_bit)
    else $error("processing without bypass_disable"); // see RL5

  property p_gain_zero_bypass;
    @(posedge ref_clk) disable iff (!rst_n) !byp_dis |=> gain_q == APG_GAIN_RESET;
  endproperty
  a_gain_zero_bypass: assert property (p_gain_zero_bypass)
    else $error("gain not 0 dB in bypass"); // see RL7

  property p_gain_range;
    @(posedge ref_clk) disable iff (!rst_n) gain_q <= APG_GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range"); // see RL6

  property p_fill_time;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == APG_ST_BYPASS && byp_dis) ##1 byp_dis [*4] |=> use_proc;
  endproperty
  a_fill_time: assert property (p_fill_time) else $error("refill length wrong"); // see RL12

  property p_proc_lat;
    @(posedge ref_clk) disable iff (!rst_n)
    // the product register took its gain code two edges before the output flop
    (warm && use_proc && gain_q == APG_GAIN_RESET && $stable(gain_q)
      && $past(gain_q, 2) == APG_GAIN_RESET && !fmt_twos && !res12_q)
      ##1 use_proc |-> out_data == $past(raw_sample, 14);
  endproperty
  a_proc_lat: assert property (p_proc_lat) else $error("processed latency wrong"); // see RL4

  property p_enter_after_bit;
    @(posedge ref_clk) disable iff (!rst_n) s_enter_proc |-> $past(byp_dis, 5);
  endproperty
  a_enter_after_bit: assert property (p_enter_after_bit)
    else $error("processing entered early"); // see RL5

  property p_saturate_top;
    @(posedge ref_clk) disable iff (!rst_n)
    (gif.in_data == APG_OB_MAX) |-> ##2 gif.out_data == APG_OB_MAX;
  endproperty
  a_saturate_top: assert property (p_saturate_top) else $error("gain wrapped at top"); // see RL13

endmodule : apg_top

// ---- bench/apg_capture.sv ----
// apg_capture: downstream capture model, latches each output word on the rising edge
// assumes: same ref_clk as the converter, async active low reset
`timescale 1ns/1ns
module apg_capture
  import apg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [13:0] out_data,
  input wire logic proc_active,
  output logic [13:0] cap_word,
  output logic cap_proc
);
  // ===========================================================
  // capture register
  // ===========================================================
  // one word per rising edge, so every check on cap_word or cap_proc sees exactly one extra cycle of delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_word <= APG_MID;  // park at midscale while held in reset
      cap_proc <= 1'b0;
    end else begin
      cap_word <= out_data;
      cap_proc <= proc_active;
    end
  end
endmodule : apg_capture

// ---- bench/adc_post_processing_bypass_gain_tb.sv ----
// testbench for the output processing path: ramp stimulus, capture model, scenario tasks
// assumes: apg_pkg, apg_gain_if, apg_gain and apg_top compiled first
`timescale 1ns/1ns
module adc_post_processing_bypass_gain_tb;
  import apg_pkg::*;
  // ===========================================================
  // signals and bookkeeping
  // ===========================================================
  localparam int LB = 11;  // bypass: 10 cycles of latency plus the capture flop
  localparam int LP = 15;  // processed: 14 cycles of latency plus the capture flop
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] raw_sample = 14'h0000;
  logic bypass_disable = 1'b0;
  logic [3:0] gain_sel = 4'h0;
  logic twos_comp = 1'b0;
  logic res12 = 1'b0;
  logic [13:0] out_data;
  logic proc_active;
  logic [13:0] cap_word;
  logic cap_proc;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;                    // rising edges seen so far
  logic [13:0] samp [64];         // history of driven samples
  logic [13:0] base = 14'h0100;   // ramp start
  logic [13:0] step = 14'h0111;   // ramp increment
  always #2 ref_clk = ~ref_clk;
  apg_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .raw_sample(raw_sample),
    .bypass_disable(bypass_disable), .gain_sel(gain_sel), .twos_comp(twos_comp),
    .res12(res12), .out_data(out_data), .proc_active(proc_active));
  apg_capture cap (.ref_clk(ref_clk), .rst_n(rst_n), .out_data(out_data),
    .proc_active(proc_active), .cap_word(cap_word), .cap_proc(cap_proc));
  // ===========================================================
  // stimulus: a 16-step ramp, one new sample per edge, recorded for the expectations
  // ===========================================================
  always @(posedge ref_clk) cyc <= cyc + 1;
  // driven 1 ns after the edge so the next edge samples it cleanly
  always @(posedge ref_clk) begin
    #1;
    raw_sample = base + step * {10'h000, cyc[3:0]};
    samp[cyc[5:0]] = raw_sample;
  end
  // ===========================================================
  // helpers
  // ===========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  function automatic logic [13:0] past(input int off);
    past = samp[6'((cyc - off) & 63)];
  endfunction : past
  // ideal gain about midscale with clamp; the multiplier table may round, so compare loosely
  function automatic int ex(input logic [13:0] s, input int n);
    real r;
    r = 8192.0 + (real'(s) - 8192.0) * (10.0 ** (n * 0.5 / 20.0));
    if (r > 16383.0) r = 16383.0;
    if (r < 0.0) r = 0.0;
    ex = $rtoi(r + 0.5);
  endfunction : ex
  task automatic near(input logic [13:0] seen, input int e);
    int d;
    d = int'(seen) - e;
    if (!$isunknown(seen) && d <= 2 && d >= -2) check(seen, seen);
    else check(seen, e);
  endtask : near
  // ===========================================================
  // scenarios
  // ===========================================================
  // bypass words, with a gain code set that must have no effect
  task automatic t_bypass(input logic tw, input logic r12);
    logic [13:0] e;
    twos_comp = tw;
    res12 = r12;
    gain_sel = 4'hC;
    tick(8);
    for (int i = 0; i < 4; i++) begin
      e = past(LB);
      if (tw) e[13] = ~e[13];
      if (r12) e[1:0] = 2'b00;
      check(cap_word, e);
      check(cap_proc, 1'b0);
      tick(1);
    end
  endtask : t_bypass
  // leave bypass at 0 dB: refill first, then the longer latency, unscaled
  task automatic t_enter();
    int n;
    twos_comp = 1'b0;
    res12 = 1'b0;
    gain_sel = 4'h0;
    tick(4);
    bypass_disable = 1'b1;
    n = 0;
    while (proc_active !== 1'b1 && n < 12) begin
      tick(1);
      n++;
    end
    check(n >= 3 && n <= 8, 1);
    tick(2);
    for (int i = 0; i < 4; i++) begin
      check(cap_word, past(LP));
      tick(1);
    end
  endtask : t_enter
  // every gain code, codes above 12 act as 12, latency stays the same
  task automatic t_gain();
    base = 14'h1F00;
    step = 14'h0020;
    for (int n = 0; n < 16; n++) begin
      gain_sel = 4'(n);
      tick(24);
      for (int i = 0; i < 3; i++) begin
        near(cap_word, ex(past(LP), (n > 12) ? 12 : n));
        tick(1);
      end
    end
  endtask : t_gain
  // full scale at 6 dB clamps at both ends instead of wrapping
  task automatic t_sat();
    gain_sel = 4'hC;
    base = 14'h3FFF;
    step = 14'h0000;
    tick(24);
    check(cap_word, 14'h3FFF);
    base = 14'h0000;
    tick(24);
    check(cap_word, 14'h0000);
  endtask : t_sat
  // return to bypass while a gain is still selected
  task automatic t_leave();
    int n;
    base = 14'h0100;
    step = 14'h0111;
    bypass_disable = 1'b0;
    n = 0;
    while (proc_active !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    check(n <= 4, 1);
    tick(14);
    for (int i = 0; i < 3; i++) begin
      check(cap_word, past(LB));
      tick(1);
    end
  endtask : t_leave
  // reset in mid-run from the processing path
  task automatic t_rereset();
    bypass_disable = 1'b1;
    tick(14);
    rst_n = 1'b0;
    bypass_disable = 1'b0;
    tick(1);
    check(out_data, 14'h2000);
    check(proc_active, 1'b0);
    tick(1);
    rst_n = 1'b1;
    tick(16);
    check(cap_word, past(LB));
    check(cap_proc, 1'b0);
  endtask : t_rereset
  // ===========================================================
  // verdict and main sequence
  // ===========================================================
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // the run needs well under 1000 cycles; 3000 leaves room without hiding a hang
  initial begin
    #(4 * 3000);
    err_total++;
    close_out();
  end
  initial begin
    tick(1);
    check(out_data, 14'h2000);
    check(proc_active, 1'b0);
    tick(1);
    rst_n = 1'b1;
    tick(12);
    for (int f = 0; f < 4; f++) t_bypass(f[0], f[1]);
    t_enter();
    t_gain();
    t_sat();
    t_leave();
    t_rereset();
    close_out();
  end
endmodule : adc_post_processing_bypass_gain_tb
